// [src/iwh_pkg.sv]
// Constants, types and behaviour list of the interrupt, watchdog and halt block.
// Behaviour
// - Conversion done sets flag, calls 0CH, clears enable.
// - No acknowledge until global enable returns.
// - Irq return sets global enable; plain return not.
// - Requests serviced at next phase-two pulse.
// - Priority external, timer, conversion; global enable masks.
// - Flags and enables share control register 0BH.
// - Request flags stay set until serviced or cleared.
// - Halt stops oscillator, ignores external clock.
// - RC mode drives clock divided by four out.
// - Option picks RC or instruction clock watchdog.
// - Disabled watchdog ignores all watchdog operations.
// - RC watchdog clock divided by 32768 timeout.
// - Instruction-clocked watchdog stops during halt.
// - Overflow resets chip; in halt warm reset.
// - Reset pin, clear op, halt clear watchdog.
// - Single or paired clear instructions per option.
// - Halt entry sets powerdown, clears timeout, clears watchdog.
// - Four wake sources leave halt.
// - Per-bit port wake enables, resume next instruction.
// - Interrupt wake services only if allowed.
// - Flag pending at halt entry cannot wake.
// - Wake inserts 1024 cycle delay before resume.
// - External falling edge sets flag, calls 04H.
// - Timer overflow sets flag, calls 08H.
// - Control bits: enables 0-3, flags 4-6, bit7 zero.
package iwh_pkg;
    localparam logic [7:0]  IDX_IRQ_CTRL  = 8'h0b;
    localparam logic [11:0] ADDR_IRQ_CTRL = {2'h0, IDX_IRQ_CTRL, 2'h0};
    localparam logic [11:0] ADDR_OPTION   = 12'h040;
    localparam logic [11:0] ADDR_STATUS   = 12'h044;
    localparam int          CTRL_W        = 7;
    localparam logic [6:0]  CTRL_RST      = 7'h00;
    localparam int          B_GIE         = 0;
    localparam int          B_EN          = 1;
    localparam int          B_FLAG        = 4;
    localparam int          OPT_W         = 16;
    localparam logic [15:0] OPT_RST       = 16'h0003;
    localparam int          O_WDT_EN      = 0;
    localparam int          O_WDT_RC      = 1;
    localparam int          O_DUAL        = 2;
    localparam int          O_RC_OSC      = 3;
    localparam int          O_WAKE        = 8;
    localparam logic [10:0] VEC_EXT       = 11'h004;
    localparam logic [10:0] VEC_TMR       = 11'h008;
    localparam logic [10:0] VEC_CONV      = 11'h00c;
    localparam logic [10:0] WAKE_CYCLES   = 11'h400;
    localparam logic [10:0] WAKE_ONE      = 11'h001;
    localparam logic [1:0]  PH2_PHASE     = 2'h1;
    localparam int          PIN_W         = 11;
    localparam int          P_IRQ         = 8;
    localparam int          P_RST         = 9;
    localparam int          P_WDT         = 10;
    localparam logic [10:0] PIN_IDLE      = 11'h3ff;

    typedef struct packed {
        logic ret_irq;
        logic ret_sub;
        logic wd_clr;
        logic wd_clr1;
        logic wd_clr2;
        logic halt;
    } iwh_ops_t;

    typedef struct packed {
        logic        call;
        logic [10:0] vector;
    } iwh_call_t;

    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_HALT = 2'b01,
        PWR_WAKE = 2'b10
    } iwh_pwr_t;
endpackage

// [src/iwh_ctrl.sv]
// Interrupt controller, watchdog and halt sequencer behind an APB slave.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module iwh_ctrl #(
    parameter int WDT_DIV = 32768
) (
    input  logic               pclk,
    input  logic               presetn,
    input  logic               psel,
    input  logic               penable,
    input  logic               pwrite,
    input  logic [11:0]        paddr,
    input  logic [31:0]        pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  iwh_pkg::iwh_ops_t  ops,
    input  logic               stack_full,
    input  logic               timer_ovf,
    input  logic               adc_done,
    input  logic               ext_irq_pin_n,
    input  logic               ext_reset_pin_n,
    input  logic [7:0]         port_a,
    input  logic               wdt_osc_in,
    output iwh_pkg::iwh_call_t irq_call,
    output logic               phase_two_pulse,
    output logic               sys_osc_enable,
    output logic               cpu_hold,
    output logic               chip_reset,
    output logic               warm_reset,
    output logic               osc_out_pin
);
    localparam int          WD_W    = $clog2(WDT_DIV);
    localparam logic [WD_W-1:0] WD_LAST = WD_W'(WDT_DIV - 1);

    function automatic logic iwh_hit(input logic [11:0] a);
        iwh_hit = (a == iwh_pkg::ADDR_IRQ_CTRL) || (a == iwh_pkg::ADDR_OPTION) ||
                  (a == iwh_pkg::ADDR_STATUS);
    endfunction

    function automatic logic [2:0] iwh_grant(input logic [2:0] p);
        if (p[0]) begin
            iwh_grant = 3'h1;
        end else if (p[1]) begin
            iwh_grant = 3'h2;
        end else if (p[2]) begin
            iwh_grant = 3'h4;
        end else begin
            iwh_grant = 3'h0;
        end
    endfunction

    logic [iwh_pkg::PIN_W-1:0]  pin_raw;
    logic [iwh_pkg::PIN_W-1:0]  s1_reg;
    logic [iwh_pkg::PIN_W-1:0]  s2_reg;
    logic [iwh_pkg::PIN_W-1:0]  s3_reg;
    logic [iwh_pkg::PIN_W-1:0]  filt_reg;
    logic [iwh_pkg::PIN_W-1:0]  filt_next;
    logic [iwh_pkg::PIN_W-1:0]  fall;
    logic [iwh_pkg::PIN_W-1:0]  rise;
    logic                       rst_low;
    logic [1:0]                 div_reg;
    logic                       osc_out_reg;
    logic [iwh_pkg::CTRL_W-1:0] ctrl_reg;
    logic [iwh_pkg::CTRL_W-1:0] ctrl_next;
    logic [iwh_pkg::OPT_W-1:0]  opt_reg;
    logic [2:0]                 set_ev;
    logic [2:0]                 pend;
    logic [2:0]                 grant;
    logic                       take;
    logic                       ctrl_zero;
    logic                       call_reg;
    logic [10:0]                vec_reg;
    logic [10:0]                vec_sel;
    iwh_pkg::iwh_pwr_t          pwr_reg;
    iwh_pkg::iwh_pwr_t          pwr_next;
    logic [10:0]                wake_cnt_reg;
    logic [2:0]                 wake_en_reg;
    logic                       halt_go;
    logic                       wake_ev;
    logic                       wd_en;
    logic                       wd_tick;
    logic                       wd_soft;
    logic                       wd_clr;
    logic                       wd_ovf;
    logic [WD_W-1:0]            wd_cnt_reg;
    logic                       arm1_reg;
    logic                       arm2_reg;
    logic                       to_reg;
    logic                       pdf_reg;
    logic                       chip_rst_reg;
    logic                       warm_rst_reg;
    logic                       acc;
    logic                       wr_ctrl;
    logic                       wr_opt;
    logic [31:0]                prdata_reg;
    logic [31:0]                rd_mux;

    // Pins pass three stages; a level is believed once the last two agree.
    assign pin_raw = {wdt_osc_in, ext_reset_pin_n, ext_irq_pin_n, port_a};
    assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
    assign fall = filt_reg & ~filt_next;
    assign rise = ~filt_reg & filt_next;
    assign rst_low = ~filt_reg[iwh_pkg::P_RST];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg   <= iwh_pkg::PIN_IDLE;
            s2_reg   <= iwh_pkg::PIN_IDLE;
            s3_reg   <= iwh_pkg::PIN_IDLE;
            filt_reg <= iwh_pkg::PIN_IDLE;
        end else begin
            s1_reg   <= pin_raw;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    // Instruction clock divider; it freezes in halt because the oscillator is off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg     <= 2'h0;
            osc_out_reg <= 1'b0;
        end else if (pwr_reg != iwh_pkg::PWR_HALT) begin
            div_reg     <= div_reg + 2'h1;
            osc_out_reg <= opt_reg[iwh_pkg::O_RC_OSC] & div_reg[1];
        end
    end

    assign phase_two_pulse = (div_reg == iwh_pkg::PH2_PHASE) && (pwr_reg != iwh_pkg::PWR_HALT);
    assign osc_out_pin     = osc_out_reg;
    assign sys_osc_enable  = (pwr_reg != iwh_pkg::PWR_HALT);
    assign cpu_hold        = (pwr_reg != iwh_pkg::PWR_RUN);

    // APB slave: zero wait states, read data captured in the setup cycle.
    assign acc     = psel & penable;
    assign wr_ctrl = acc & pwrite & (paddr == iwh_pkg::ADDR_IRQ_CTRL);
    assign wr_opt  = acc & pwrite & (paddr == iwh_pkg::ADDR_OPTION);
    assign pready  = 1'b1;
    assign pslverr = acc & ~iwh_hit(paddr);
    assign prdata  = prdata_reg;

    always_comb begin
        rd_mux = 32'h0;
        if (paddr == iwh_pkg::ADDR_IRQ_CTRL) begin
            rd_mux[iwh_pkg::CTRL_W-1:0] = ctrl_reg;
        end else if (paddr == iwh_pkg::ADDR_OPTION) begin
            rd_mux[iwh_pkg::OPT_W-1:0] = opt_reg;
        end else if (iwh_hit(paddr)) begin
            rd_mux[3:0] = {pwr_reg == iwh_pkg::PWR_WAKE, pwr_reg == iwh_pkg::PWR_HALT,
                           pdf_reg, to_reg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_reg <= iwh_pkg::OPT_RST;
        end else if (wr_opt) begin
            opt_reg <= pwdata[iwh_pkg::OPT_W-1:0];
        end
    end

    // Interrupt requests and service.
    assign set_ev = {adc_done, timer_ovf, fall[iwh_pkg::P_IRQ]};
    assign pend   = ctrl_reg[iwh_pkg::B_FLAG +: 3] & ctrl_reg[iwh_pkg::B_EN +: 3];
    assign grant  = iwh_grant(pend);
    // Global enable gates every source, so a running routine blocks nesting.
    assign take   = phase_two_pulse && (pwr_reg == iwh_pkg::PWR_RUN) && !stack_full &&
                    ctrl_reg[iwh_pkg::B_GIE] && (|pend);
    assign ctrl_zero = rst_low | (wd_ovf & (pwr_reg == iwh_pkg::PWR_RUN));

    always_comb begin
        vec_sel = iwh_pkg::VEC_CONV;
        if (grant[0]) begin
            vec_sel = iwh_pkg::VEC_EXT;
        end else if (grant[1]) begin
            vec_sel = iwh_pkg::VEC_TMR;
        end
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = pwdata[iwh_pkg::CTRL_W-1:0];
        end
        if (ops.ret_irq) begin
            ctrl_next[iwh_pkg::B_GIE] = 1'b1;
        end
        if (take) begin
            ctrl_next[iwh_pkg::B_GIE] = 1'b0;
            ctrl_next[iwh_pkg::B_FLAG +: 3] = ctrl_next[iwh_pkg::B_FLAG +: 3] & ~grant;
        end
        // A new event beats a write or service clear in the same cycle; a reset beats both.
        ctrl_next[iwh_pkg::B_FLAG +: 3] = ctrl_next[iwh_pkg::B_FLAG +: 3] | set_ev;
        if (ctrl_zero) begin
            ctrl_next = iwh_pkg::CTRL_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= iwh_pkg::CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // The core pushes only its program counter on this call; status is not saved.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_reg <= 1'b0;
            vec_reg  <= 11'h000;
        end else begin
            call_reg <= take;
            if (take) begin
                vec_reg <= vec_sel;
            end
        end
    end

    assign irq_call = '{call: call_reg, vector: vec_reg};

    // Power sequencing.
    assign halt_go = ops.halt && (pwr_reg == iwh_pkg::PWR_RUN) && !rst_low && !wd_ovf;
    assign wake_ev = (|(set_ev & wake_en_reg)) |
                     (|(fall[7:0] & opt_reg[iwh_pkg::O_WAKE +: 8])) | wd_ovf;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_en_reg <= 3'h0;
        end else if (halt_go) begin
            wake_en_reg <= ~(ctrl_reg[iwh_pkg::B_FLAG +: 3] | set_ev);
        end
    end

    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            iwh_pkg::PWR_RUN: begin
                if (halt_go) begin
                    pwr_next = iwh_pkg::PWR_HALT;
                end else if (wd_ovf) begin
                    pwr_next = iwh_pkg::PWR_WAKE;
                end
            end
            iwh_pkg::PWR_HALT: begin
                if (wake_ev) begin
                    pwr_next = iwh_pkg::PWR_WAKE;
                end
            end
            iwh_pkg::PWR_WAKE: begin
                if (wake_cnt_reg == iwh_pkg::WAKE_ONE) begin
                    pwr_next = iwh_pkg::PWR_RUN;
                end
            end
            default: pwr_next = iwh_pkg::PWR_RUN;
        endcase
        if (rst_low) begin
            pwr_next = iwh_pkg::PWR_WAKE;
        end
    end

    // Start-up delay also follows power-up and every reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg      <= iwh_pkg::PWR_WAKE;
            wake_cnt_reg <= iwh_pkg::WAKE_CYCLES;
        end else begin
            pwr_reg <= pwr_next;
            if (rst_low || (pwr_reg != iwh_pkg::PWR_WAKE)) begin
                wake_cnt_reg <= iwh_pkg::WAKE_CYCLES;
            end else begin
                wake_cnt_reg <= wake_cnt_reg - iwh_pkg::WAKE_ONE;
            end
        end
    end

    // Watchdog. Instruction-clock ticks stop in halt, so it cannot time out and wake the chip then.
    assign wd_en   = opt_reg[iwh_pkg::O_WDT_EN];
    assign wd_tick = opt_reg[iwh_pkg::O_WDT_RC] ? rise[iwh_pkg::P_WDT] : phase_two_pulse;
    assign wd_soft = wd_en & (opt_reg[iwh_pkg::O_DUAL] ?
                     ((arm1_reg | ops.wd_clr1) & (arm2_reg | ops.wd_clr2)) : ops.wd_clr);
    assign wd_clr  = rst_low | (wd_en & halt_go) | wd_soft;
    assign wd_ovf  = wd_en & wd_tick & (wd_cnt_reg == WD_LAST) & ~wd_clr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_reg <= '0;
        end else if (wd_clr || wd_ovf) begin
            wd_cnt_reg <= '0;
        end else if (wd_en && wd_tick) begin
            wd_cnt_reg <= wd_cnt_reg + WD_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm1_reg <= 1'b0;
            arm2_reg <= 1'b0;
        end else if (wd_soft || rst_low) begin
            arm1_reg <= 1'b0;
            arm2_reg <= 1'b0;
        end else if (wd_en && opt_reg[iwh_pkg::O_DUAL]) begin
            arm1_reg <= arm1_reg | ops.wd_clr1;
            arm2_reg <= arm2_reg | ops.wd_clr2;
        end
    end

    // Later assignments win, so a timeout is never lost to a clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_reg  <= 1'b0;
            pdf_reg <= 1'b0;
        end else begin
            if (wd_soft) begin
                to_reg  <= 1'b0;
                pdf_reg <= 1'b0;
            end
            if (halt_go) begin
                pdf_reg <= 1'b1;
                to_reg  <= 1'b0;
            end
            if (wd_ovf) begin
                to_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_rst_reg <= 1'b0;
            warm_rst_reg <= 1'b0;
        end else begin
            chip_rst_reg <= rst_low | (wd_ovf & (pwr_reg == iwh_pkg::PWR_RUN));
            warm_rst_reg <= wd_ovf & (pwr_reg == iwh_pkg::PWR_HALT);
        end
    end

    assign chip_reset = chip_rst_reg;
    assign warm_reset = warm_rst_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_enter_wake;
        (pwr_reg != iwh_pkg::PWR_WAKE) ##1 (pwr_reg == iwh_pkg::PWR_WAKE);
    endsequence

    AST_EXT_FIRST: assert property ((take && pend[0]) |=>
        (irq_call.call && irq_call.vector == iwh_pkg::VEC_EXT)) else $error("ext vector wrong");
    AST_CONV_CALL: assert property ((take && pend == 3'h4 && !adc_done && !ctrl_zero) |=>
        (irq_call.vector == iwh_pkg::VEC_CONV && !ctrl_reg[iwh_pkg::B_FLAG + 2]))
        else $error("conversion call wrong");
    AST_TAKE_GIE: assert property ((take && !wr_ctrl) |=> !ctrl_reg[iwh_pkg::B_GIE])
        else $error("global enable not cleared");
    AST_RETURN_FROM_IRQ_OP: assert property ((ops.ret_irq && !take && !wr_ctrl && !ctrl_zero) |=>
        ctrl_reg[iwh_pkg::B_GIE]) else $error("return did not enable");
    AST_PH2: assert property (take |-> (phase_two_pulse && !stack_full))
        else $error("service off phase");
    AST_FLAG_HOLD: assert property ((ctrl_reg[iwh_pkg::B_FLAG] && !take && !wr_ctrl &&
        !ctrl_zero) |=> ctrl_reg[iwh_pkg::B_FLAG]) else $error("flag lost");
    AST_HALT_OSC: assert property ((pwr_reg == iwh_pkg::PWR_HALT) |->
        (!sys_osc_enable && !phase_two_pulse)) else $error("clock running in halt");
    AST_WAKE_LOAD: assert property (seq_enter_wake |->
        (wake_cnt_reg == iwh_pkg::WAKE_CYCLES)) else $error("wake delay not loaded");
    AST_WAKE_END: assert property ((pwr_reg == iwh_pkg::PWR_WAKE && !rst_low &&
        wake_cnt_reg == iwh_pkg::WAKE_ONE) |=> (pwr_reg == iwh_pkg::PWR_RUN))
        else $error("wake delay wrong");
    AST_HALT_ENTRY: assert property (halt_go |=> ((pwr_reg == iwh_pkg::PWR_HALT) &&
        pdf_reg && !to_reg)) else $error("halt entry wrong");
    AST_WD_RUN: assert property ((wd_ovf && pwr_reg == iwh_pkg::PWR_RUN) |=>
        (chip_reset && to_reg && ctrl_reg == iwh_pkg::CTRL_RST)) else $error("chip reset wrong");
    AST_WD_WARM: assert property ((wd_ovf && pwr_reg == iwh_pkg::PWR_HALT) |=>
        (warm_reset && to_reg && pdf_reg && !chip_reset)) else $error("warm reset wrong");
    AST_WD_OFF: assert property ((!wd_en && !rst_low) |=> $stable(wd_cnt_reg))
        else $error("disabled watchdog moved");
endmodule // iwh_ctrl

// [dv/iwh_core_model.sv]
// Core stand-in that tracks stack depth from interrupt calls and returns.
`timescale 1ns/10ps
module iwh_core_model #(
    parameter int DEPTH = 6
) (
    input  logic               pclk,
    input  logic               presetn,
    input  iwh_pkg::iwh_ops_t  ops,
    input  iwh_pkg::iwh_call_t irq_call,
    input  logic               full_req,
    output logic               stack_full
);
    int depth_reg;
    logic ret;
    assign ret = ops.ret_irq | ops.ret_sub;
    // Only the return address is pushed; status stays with software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_reg <= 0;
        end else if (irq_call.call && !ret) begin
            depth_reg <= depth_reg + 1;
        end else if (!irq_call.call && ret && depth_reg > 0) begin
            depth_reg <= depth_reg - 1;
        end
    end
    // The bench can also force a full stack to test refusal.
    assign stack_full = full_req || (depth_reg >= DEPTH);
endmodule // iwh_core_model

// [dv/irq_watchdog_halt_control_test.sv]
// Self-checking bench for the interrupt, watchdog and halt block.
`timescale 1ns/10ps
module irq_watchdog_halt_control_test;
    localparam logic [11:0] CTL = iwh_pkg::ADDR_IRQ_CTRL;
    localparam logic [11:0] OPT = iwh_pkg::ADDR_OPTION;
    localparam logic [11:0] STA = iwh_pkg::ADDR_STATUS;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err, seen;
    logic               stack_full, timer_ovf, adc_done, ext_irq_pin_n, ext_reset_pin_n;
    logic               wdt_osc_in, phase_two_pulse, sys_osc_enable, cpu_hold, chip_reset;
    logic               warm_reset, osc_out_pin, full_req, a, b;
    logic [2:0]         f;
    logic [7:0]         port_a;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    iwh_pkg::iwh_ops_t  ops;
    iwh_pkg::iwh_call_t irq_call;
    int                 fails, comparisons, n, n_chip, n_warm, base, bit_i;
    int                 opt_tab[4] = '{1, 5, 5, 0};

    iwh_ctrl #(.WDT_DIV(16)) u_iwh_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ops(ops), .stack_full(stack_full),
        .timer_ovf(timer_ovf), .adc_done(adc_done), .ext_irq_pin_n(ext_irq_pin_n),
        .ext_reset_pin_n(ext_reset_pin_n), .port_a(port_a), .wdt_osc_in(wdt_osc_in),
        .irq_call(irq_call), .phase_two_pulse(phase_two_pulse),
        .sys_osc_enable(sys_osc_enable), .cpu_hold(cpu_hold), .chip_reset(chip_reset),
        .warm_reset(warm_reset), .osc_out_pin(osc_out_pin));
    iwh_core_model u_iwh_core_model (.pclk(pclk), .presetn(presetn), .ops(ops),
        .irq_call(irq_call), .full_req(full_req), .stack_full(stack_full));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // The watchdog oscillator runs free and unrelated to the system clock.
    initial begin
        wdt_osc_in = 1'b0;
        forever #13 wdt_osc_in = ~wdt_osc_in;
    end
    always @(posedge pclk) begin
        if (chip_reset === 1'b1) n_chip++;
        if (warm_reset === 1'b1) n_warm++;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        wrap_up();
    end

    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input iwh_pkg::iwh_ops_t o, input logic t, input logic ad);
        @(posedge pclk);
        ops       <= o;
        timer_ovf <= t;
        adc_done  <= ad;
        @(posedge pclk);
        ops       <= 6'h00;
        timer_ovf <= 1'b0;
        adc_done  <= 1'b0;
    endtask
    task automatic wait_call(input int lim, output logic s);
        s = 1'b0;
        for (int i = 0; i < lim && !s; i++) begin
            @(posedge pclk);
            #1;
            s = (irq_call.call === 1'b1);
        end
    endtask
    task automatic expect_call(input int lim, input logic [10:0] v);
        wait_call(lim, seen);
        chk("call", 32'h1, {31'h0, seen});
        chk("vector", {21'h0, v}, {21'h0, irq_call.vector});
    endtask
    // Counts cycles of the restart delay: held, but with the oscillator running.
    task automatic wake_len(output int c);
        c = 0;
        for (int i = 0; i < 3000 && cpu_hold !== 1'b0; i++) begin
            @(posedge pclk);
            #1;
            if (cpu_hold === 1'b1 && sys_osc_enable === 1'b1) c++;
        end
    endtask
    task automatic ph_count(output int c);
        c = 0;
        repeat (8) begin
            @(posedge pclk);
            #1;
            if (phase_two_pulse === 1'b1) c++;
        end
    endtask
    function automatic logic [2:0] low_bit(input logic [2:0] v);
        return v & (~v + 3'h1);
    endfunction
    function automatic logic [10:0] vec_of(input logic [2:0] v);
        return v[0] ? iwh_pkg::VEC_EXT : (v[1] ? iwh_pkg::VEC_TMR : iwh_pkg::VEC_CONV);
    endfunction

    initial begin
        {presetn, psel, penable, pwrite, timer_ovf, adc_done, full_req} = 7'h00;
        {ext_irq_pin_n, ext_reset_pin_n, port_a, paddr, pwdata} = '1;
        ops = 6'h00;
        n = $urandom(32'ha670c296);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OPT, 32'h0);
        chk("option", 32'h3, rd);
        apb(1'b1, OPT, 32'h0);
        apb(1'b0, CTL, 32'h0);
        chk("ctrl", 32'h0, rd);
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        wake_len(n);
        ph_count(n);
        chk("phase", 32'h2, n);
        for (int k = 0; k < 8; k++) begin
            f = 3'($urandom_range(7, 1));
            apb(1'b1, CTL, {25'h0, f, 4'h0});
            apb(1'b0, CTL, 32'hff);
            chk("flags", {25'h0, f, 4'h0}, rd);
            apb(1'b1, CTL, {25'h0, f, 4'hf});
            while (f != 3'h0) begin
                expect_call(40, vec_of(f));
                f = f & ~low_bit(f);
                apb(1'b0, CTL, 32'h0);
                chk("ctrl", {25'h0, f, 4'he}, rd);
                pulse(6'h20, 1'b0, 1'b0);
            end
        end
        full_req <= 1'b1;
        apb(1'b1, CTL, 32'h27);
        wait_call(40, seen);
        chk("full", 32'h0, {31'h0, seen});
        @(posedge pclk);
        full_req <= 1'b0;
        expect_call(40, iwh_pkg::VEC_TMR);
        pulse(6'h10, 1'b0, 1'b0);
        pulse(6'h00, 1'b1, 1'b0);
        wait_call(40, seen);
        chk("masked", 32'h0, {31'h0, seen});
        pulse(6'h20, 1'b0, 1'b0);
        expect_call(40, iwh_pkg::VEC_TMR);
        apb(1'b1, CTL, 32'h03);
        ext_irq_pin_n <= 1'b0;
        expect_call(40, iwh_pkg::VEC_EXT);
        @(posedge pclk);
        ext_irq_pin_n <= 1'b1;
        apb(1'b1, CTL, 32'h09);
        pulse(6'h00, 1'b0, 1'b1);
        expect_call(40, iwh_pkg::VEC_CONV);
        bit_i = $urandom_range(7, 0);
        apb(1'b1, OPT, 32'h1 << (8 + bit_i));
        apb(1'b1, CTL, 32'h20);
        pulse(6'h01, 1'b0, 1'b0);
        ph_count(n);
        chk("halt phase", 32'h0, n);
        chk("halt osc", 32'h0, {31'h0, sys_osc_enable});
        pulse(6'h00, 1'b1, 1'b0);
        repeat (8) @(posedge pclk);
        #1;
        chk("still halted", 32'h1, {31'h0, cpu_hold & ~sys_osc_enable});
        fork
            wake_len(n);
            begin
                repeat (10) @(posedge pclk);
                port_a[bit_i] <= 1'b0;
            end
        join
        chk("wake delay", 32'd1024, n);
        @(posedge pclk);
        port_a <= 8'hff;
        apb(1'b0, STA, 32'h0);
        chk("status", 32'h2, rd & 32'hf);
        apb(1'b1, CTL, 32'h09);
        pulse(6'h01, 1'b0, 1'b0);
        pulse(6'h00, 1'b0, 1'b1);
        expect_call(1200, iwh_pkg::VEC_CONV);
        pulse(6'h20, 1'b0, 1'b0);
        apb(1'b1, CTL, 32'h0e);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OPT, opt_tab[k]);
            base = n_chip;
            for (int i = 0; i < 15; i++) begin
                repeat (20) @(posedge pclk);
                pulse(k == 0 ? 6'h08 : (k == 1 && !i[0] ? 6'h02 : 6'h04), 1'b0, 1'b0);
            end
            chk("wd reset", {31'h0, k == 2}, {31'h0, n_chip != base});
            if (k == 2) begin
                wake_len(n);
                apb(1'b0, STA, 32'h0);
                chk("timeout", 32'h1, rd & 32'h1);
                apb(1'b0, CTL, 32'h0);
                chk("ctrl cleared", 32'h0, rd);
            end
        end
        apb(1'b1, OPT, 32'h8);
        @(posedge pclk);
        #1;
        a = osc_out_pin;
        repeat (2) @(posedge pclk);
        #1;
        b = osc_out_pin;
        chk("osc out", 32'h1, {31'h0, a ^ b});
        apb(1'b1, CTL, 32'h0e);
        apb(1'b1, OPT, 32'h3);
        pulse(6'h01, 1'b0, 1'b0);
        base = n_warm;
        for (int i = 0; i < 400 && n_warm == base; i++) @(posedge pclk);
        chk("warm", 32'h1, {31'h0, n_warm != base});
        apb(1'b0, STA, 32'h0);
        apb(1'b1, OPT, 32'h0);
        chk("warm flags", 32'h3, rd & 32'h3);
        apb(1'b0, CTL, 32'h0);
        chk("ctrl kept", 32'h0e, rd);
        ext_reset_pin_n <= 1'b0;
        repeat (6) @(posedge pclk);
        #1;
        chk("pin reset", 32'h1, {31'h0, chip_reset});
        wrap_up();
    end
endmodule // irq_watchdog_halt_control_test
